// File: logic/pcm_pkg.sv
// Package with register map, reset values and pin-function encodings of the port pin mux.
package pcm_pkg;
    localparam logic [7:0] ADDR_PIN_LEVELS    = 8'h00;
    localparam logic [7:0] ADDR_OUTPUT_LATCH  = 8'h04;
    localparam logic [7:0] ADDR_DIRECTION     = 8'h08;
    localparam logic [7:0] ADDR_ANALOG_LOW    = 8'h0C;
    localparam logic [7:0] ADDR_ANALOG_HIGH   = 8'h10;
    localparam logic [7:0] ADDR_EDGE_RATE     = 8'h14;
    localparam logic [7:0] ADDR_FUNC_CTRL     = 8'h18;

    localparam logic [7:0] RST_LATCH          = 8'h00;
    localparam logic [7:0] RST_DIRECTION      = 8'hFF;
    localparam logic [7:0] RST_ANALOG_LOW     = 8'hF8;
    localparam logic [7:0] RST_ANALOG_HIGH    = 8'h0F;
    localparam logic [7:0] RST_EDGE_RATE      = 8'h07;
    localparam logic [7:0] RST_FUNC_CTRL      = 8'h00;

    localparam logic [7:0] MASK_ANALOG_LOW    = 8'hF8;
    localparam logic [7:0] MASK_ANALOG_HIGH   = 8'h0F;
    localparam logic [7:0] MASK_EDGE_RATE     = 8'h07;
    localparam logic [7:0] MASK_FUNC_CTRL     = 8'h0F;

    localparam int         BIT_ANALOG_PIN6    = 0;
    localparam int         BIT_ANALOG_PIN7    = 1;
    localparam int         BIT_FC_CCP_OUT     = 0;
    localparam int         BIT_FC_PWM_A       = 1;
    localparam int         BIT_FC_SERIAL      = 2;
    localparam int         BIT_FC_OSC         = 3;

    localparam logic [1:0] RESP_OKAY          = 2'h0;
    localparam logic [1:0] RESP_SLVERR        = 2'h2;

    typedef enum logic [1:0] {
        PCM_FN_LATCH = 2'b00,
        PCM_FN_PERIPH = 2'b01,
        PCM_FN_HIZ   = 2'b10,
        PCM_FN_ANALOG = 2'b11
    } pcm_fn_t;
endpackage : pcm_pkg

// File: logic/pcm_pin_cell.sv
// One pin cell: output select, enable and digital input gating.
`timescale 1ns/100ps
module pcm_pin_cell (
    input  wire logic           latch_bit,   // Port latch value
    input  wire logic           dir_bit,     // Direction bit, 1 is input
    input  wire logic           analog_select_low_bit,   // Analog select for the input path
    input  wire logic           periph_own,  // Peripheral owns the output
    input  wire logic           periph_data, // Peripheral output value
    input  wire logic           periph_hiz,  // Peripheral asks for high impedance
    input  wire logic           osc_own,     // Oscillator owns the pin
    input  wire logic           pin_in,      // Pin level
    output      logic           pin_out,     // Value driven on the pin
    output      logic           pin_oe_n,    // Low while the pin is driven
    output      logic           dig_in       // Digital input after gating
);
    always_comb begin
        pin_out  = 1'b0;
        pin_oe_n = 1'b1;
        if (osc_own) begin
            pin_out  = 1'b0;
            pin_oe_n = 1'b1;
        end else if (periph_own) begin
            pin_out  = periph_data;
            pin_oe_n = periph_hiz;
        end else begin
            pin_out  = latch_bit;
            pin_oe_n = dir_bit;
        end
        dig_in = pin_in & ~analog_select_low_bit & ~osc_own;
    end
endmodule : pcm_pin_cell

// File: logic/pcm_regs.sv
// Register storage for the port latch, direction, analog select, edge rate and function control.
`timescale 1ns/100ps
module pcm_regs (
    input  wire logic           aclk,      // Core clock
    input  wire logic           aresetn,   // Synchronous reset, active low
    input  wire logic           ce,        // Clock enable
    input  wire logic           wr_en,     // Write strobe
    input  wire logic [7:0]     wr_addr,   // Write byte address
    input  wire logic [7:0]     wr_data,   // Write data, after byte lane merge
    output      logic [7:0]     latch,     // Port latch
    output      logic [7:0]     dir,       // Direction
    output      logic [7:0]     analog_select_low_lo,  // Analog select low
    output      logic [7:0]     analog_select_low_hi,  // Analog select high
    output      logic [7:0]     edge_rate, // Edge rate control
    output      logic [7:0]     func_ctrl  // Function enables
);
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
        logic [7:0] alo;
        logic [7:0] ahi;
        logic [7:0] edge_rate;
        logic [7:0] fc;
    } pcm_regs_state_t;

    pcm_regs_state_t state;
    pcm_regs_state_t next_state;

    always_comb begin
        next_state = state;
        if (wr_en) begin
            if (wr_addr == pcm_pkg::ADDR_OUTPUT_LATCH || wr_addr == pcm_pkg::ADDR_PIN_LEVELS) begin
                next_state.latch = wr_data;
            end else if (wr_addr == pcm_pkg::ADDR_DIRECTION) begin
                next_state.dir = wr_data;
            end else if (wr_addr == pcm_pkg::ADDR_ANALOG_LOW) begin
                next_state.alo = wr_data & pcm_pkg::MASK_ANALOG_LOW;
            end else if (wr_addr == pcm_pkg::ADDR_ANALOG_HIGH) begin
                next_state.ahi = wr_data & pcm_pkg::MASK_ANALOG_HIGH;
            end else if (wr_addr == pcm_pkg::ADDR_EDGE_RATE) begin
                next_state.edge_rate = wr_data & pcm_pkg::MASK_EDGE_RATE;
            end else if (wr_addr == pcm_pkg::ADDR_FUNC_CTRL) begin
                next_state.fc = wr_data & pcm_pkg::MASK_FUNC_CTRL;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state.latch     <= pcm_pkg::RST_LATCH;
            state.dir       <= pcm_pkg::RST_DIRECTION;
            state.alo       <= pcm_pkg::RST_ANALOG_LOW;
            state.ahi       <= pcm_pkg::RST_ANALOG_HIGH;
            state.edge_rate <= pcm_pkg::RST_EDGE_RATE;
            state.fc        <= pcm_pkg::RST_FUNC_CTRL;
        end else if (ce) begin
            state <= next_state;
        end
    end

    assign latch     = state.latch;
    assign dir       = state.dir;
    assign analog_select_low_lo  = state.alo;
    assign analog_select_low_hi  = state.ahi;
    assign edge_rate = state.edge_rate;
    assign func_ctrl = state.fc;
endmodule : pcm_regs

// File: logic/pcm_top.sv
// Pin mux for port pins 5 to 7 with an AXI4-Lite register slave.
// How it works
// - A compare or PWM result from the capture unit overrides the latch on pin 5 when it is an output.
// - PWM channel A overrides the latch on pin 5 and floats the pin during a shutdown event.
// - The serial port data output drives pin 7 instead of the latch while the port is active and pin 7 is an output.
// - Pin 6 feeds the serial slave-select input when its direction bit is 1.
// - Pin 6 feeds the shared 16-bit timer count input when its direction bit is 1.
// - With the low-power oscillator on, pin 6 is the oscillator input and digital I/O is off.
// - With the low-power oscillator on, pin 7 is the oscillator output and digital I/O is off.
// - Pins 6 and 7 connect to analog channels 8 and 9 when their direction bits are 1 and the low-power oscillator is off.
// - Functions that ignore the direction bit set the pin direction themselves.
// - The port latch holds one output value per pin, bits 7 to 0.
// - A set analog-select bit disables the digital input and pin reads return 0.
// - An output pin with analog select set still drives its digital output.
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module pcm_top (
    input  wire logic           aclk,           // Core clock, 125 MHz
    input  wire logic           aresetn,        // Synchronous reset, active low
    input  wire logic           ce,             // Clock enable, freezes state when low
    input  wire logic [7:0]     s_axi_awaddr,   // Write address
    input  wire logic [2:0]     s_axi_awprot,   // Write protection, unused
    input  wire logic           s_axi_awvalid,  // Write address valid
    output      logic           s_axi_awready,  // Write address ready
    input  wire logic [31:0]    s_axi_wdata,    // Write data
    input  wire logic [3:0]     s_axi_wstrb,    // Write strobes
    input  wire logic           s_axi_wvalid,   // Write data valid
    output      logic           s_axi_wready,   // Write data ready
    output      logic [1:0]     s_axi_bresp,    // Write response
    output      logic           s_axi_bvalid,   // Write response valid
    input  wire logic           s_axi_bready,   // Write response ready
    input  wire logic [7:0]     s_axi_araddr,   // Read address
    input  wire logic [2:0]     s_axi_arprot,   // Read protection, unused
    input  wire logic           s_axi_arvalid,  // Read address valid
    output      logic           s_axi_arready,  // Read address ready
    output      logic [31:0]    s_axi_rdata,    // Read data
    output      logic [1:0]     s_axi_rresp,    // Read response
    output      logic           s_axi_rvalid,   // Read data valid
    input  wire logic           s_axi_rready,   // Read data ready
    input  wire logic [2:0]     pin_in,         // Pin levels of pins 5 to 7
    output      logic [2:0]     pin_out,        // Driven values of pins 5 to 7
    output      logic [2:0]     pin_oe_n,       // Output enables, low while driven
    input  wire logic [4:0]     low_pins_in,    // Digital input of pins 0 to 4
    input  wire logic           ccp_out_en,     // Capture unit drives compare or PWM output
    input  wire logic           ccp_out,        // Compare or PWM output value
    input  wire logic           pwm_a_en,       // PWM channel A active
    input  wire logic           pwm_a,          // PWM channel A value
    input  wire logic           pwm_shutdown,   // PWM shutdown event active
    input  wire logic           pwm_sd_hiz,     // Float channel A during shutdown
    input  wire logic           serial_active,  // Serial port enabled
    input  wire logic           serial_data_out, // Serial data output
    input  wire logic           osc_enable,     // Low-power oscillator enabled
    output      logic           capture_in,     // Capture input from pin 5
    output      logic           timer8_count_input,  // 8-bit timer count input
    output      logic           timer16_count_input, // Shared 16-bit timer count input
    output      logic           slave_select_n, // Serial slave select, active low
    output      logic           analog_channel_eight, // Pin 6 routed to analog channel 8
    output      logic           analog_channel_nine,  // Pin 7 routed to analog channel 9
    output      logic           lowpower_osc_in,  // Pin 6 belongs to the oscillator input
    output      logic           lowpower_osc_out, // Pin 7 belongs to the oscillator output
    output      logic [2:0]     edge_rate_slow  // Reduced edge rate per port
);
    typedef struct packed {
        logic        aw_full;
        logic [7:0]  aw_addr;
        logic        w_full;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } pcm_bus_state_t;

    pcm_bus_state_t state;
    pcm_bus_state_t next_state;

    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] analog_select_low_lo;
    logic [7:0] analog_select_low_hi;
    logic [7:0] edge_rate;
    logic [7:0] func_ctrl;
    logic [2:0] dig_in;
    logic [2:0] periph_own;
    logic [2:0] periph_data;
    logic [2:0] periph_hiz;
    logic [2:0] osc_own;
    logic [2:0] analog_select_low_up;
    logic [7:0] pin_levels;
    logic       wr_fire;
    logic       wr_known;
    logic       rd_known;
    logic [7:0] wr_byte;
    logic [7:0] wr_base;
    logic [7:0] rd_value;
    logic       osc_on;
    logic       ccp_on;
    logic       pwm_on;
    logic       ser_on;

    // Function enables from software are ANDed with the peripheral's own request.
    assign ccp_on = ccp_out_en & func_ctrl[pcm_pkg::BIT_FC_CCP_OUT];
    assign pwm_on = pwm_a_en & func_ctrl[pcm_pkg::BIT_FC_PWM_A];
    assign ser_on = serial_active & func_ctrl[pcm_pkg::BIT_FC_SERIAL];
    assign osc_on = osc_enable & func_ctrl[pcm_pkg::BIT_FC_OSC];

    // PWM channel A outranks the compare output on pin 5.
    always_comb begin
        periph_own  = 3'b000;
        periph_data = 3'b000;
        periph_hiz  = 3'b000;
        if (pwm_on) begin
            periph_own[0]  = 1'b1;
            periph_data[0] = pwm_a;
            periph_hiz[0]  = pwm_shutdown & pwm_sd_hiz;
        end else if (ccp_on && !dir[5]) begin
            periph_own[0]  = 1'b1;
            periph_data[0] = ccp_out;
        end
        if (ser_on && !dir[7]) begin
            periph_own[2]  = 1'b1;
            periph_data[2] = serial_data_out;
        end
    end

    assign osc_own  = {osc_on, osc_on, 1'b0};
    assign analog_select_low_up = {analog_select_low_hi[pcm_pkg::BIT_ANALOG_PIN7],
                       analog_select_low_hi[pcm_pkg::BIT_ANALOG_PIN6], 1'b0};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pin
            pcm_pin_cell u_cell (
                .latch_bit   (latch[gi + 5]),
                .dir_bit     (dir[gi + 5]),
                .analog_select_low_bit   (analog_select_low_up[gi]),
                .periph_own  (periph_own[gi]),
                .periph_data (periph_data[gi]),
                .periph_hiz  (periph_hiz[gi]),
                .osc_own     (osc_own[gi]),
                .pin_in      (pin_in[gi]),
                .pin_out     (pin_out[gi]),
                .pin_oe_n    (pin_oe_n[gi]),
                .dig_in      (dig_in[gi])
            );
        end
    endgenerate

    // Digital peripheral inputs follow the gated digital input of their pin while its direction bit is 1; slave_select_n stays 1 while the oscillator is on.
    assign capture_in           = dig_in[0] & dir[5];
    assign timer8_count_input   = dig_in[0] & dir[5];
    assign timer16_count_input  = dig_in[1] & dir[6];
    assign slave_select_n       = ~(dir[6] & ~osc_on) | dig_in[1];
    assign analog_channel_eight = dir[6] & ~osc_on;
    assign analog_channel_nine  = dir[7] & ~osc_on;
    assign lowpower_osc_in      = osc_on;
    assign lowpower_osc_out     = osc_on;
    assign edge_rate_slow       = edge_rate[2:0];

    // Output pins read back their driven value, or 0 with analog select set; input pins read their gated level.
    always_comb begin
        pin_levels[4:0] = low_pins_in;
        for (int i = 0; i < 3; i++) begin
            pin_levels[i + 5] = pin_oe_n[i] ? dig_in[i] : (pin_out[i] & ~analog_select_low_up[i]);
        end
    end

    assign wr_fire = state.aw_full && state.w_full && !state.bvalid;

    always_comb begin
        wr_base = 8'h00;
        if (state.aw_addr == pcm_pkg::ADDR_OUTPUT_LATCH || state.aw_addr == pcm_pkg::ADDR_PIN_LEVELS) begin
            wr_base = latch;
        end else if (state.aw_addr == pcm_pkg::ADDR_DIRECTION) begin
            wr_base = dir;
        end else if (state.aw_addr == pcm_pkg::ADDR_ANALOG_LOW) begin
            wr_base = analog_select_low_lo;
        end else if (state.aw_addr == pcm_pkg::ADDR_ANALOG_HIGH) begin
            wr_base = analog_select_low_hi;
        end else if (state.aw_addr == pcm_pkg::ADDR_EDGE_RATE) begin
            wr_base = edge_rate;
        end else if (state.aw_addr == pcm_pkg::ADDR_FUNC_CTRL) begin
            wr_base = func_ctrl;
        end
        wr_byte = state.w_strb[0] ? state.w_data[7:0] : wr_base;
    end

    assign wr_known = (state.aw_addr == pcm_pkg::ADDR_PIN_LEVELS)
                   || (state.aw_addr == pcm_pkg::ADDR_OUTPUT_LATCH)
                   || (state.aw_addr == pcm_pkg::ADDR_DIRECTION)
                   || (state.aw_addr == pcm_pkg::ADDR_ANALOG_LOW)
                   || (state.aw_addr == pcm_pkg::ADDR_ANALOG_HIGH)
                   || (state.aw_addr == pcm_pkg::ADDR_EDGE_RATE)
                   || (state.aw_addr == pcm_pkg::ADDR_FUNC_CTRL);

    always_comb begin
        rd_value = 8'h00;
        rd_known = 1'b1;
        if (s_axi_araddr == pcm_pkg::ADDR_PIN_LEVELS) begin
            rd_value = pin_levels;
        end else if (s_axi_araddr == pcm_pkg::ADDR_OUTPUT_LATCH) begin
            rd_value = latch;
        end else if (s_axi_araddr == pcm_pkg::ADDR_DIRECTION) begin
            rd_value = dir;
        end else if (s_axi_araddr == pcm_pkg::ADDR_ANALOG_LOW) begin
            rd_value = analog_select_low_lo;
        end else if (s_axi_araddr == pcm_pkg::ADDR_ANALOG_HIGH) begin
            rd_value = analog_select_low_hi;
        end else if (s_axi_araddr == pcm_pkg::ADDR_EDGE_RATE) begin
            rd_value = edge_rate;
        end else if (s_axi_araddr == pcm_pkg::ADDR_FUNC_CTRL) begin
            rd_value = func_ctrl;
        end else begin
            rd_known = 1'b0;
        end
    end

    assign s_axi_awready = ce && !state.aw_full;
    assign s_axi_wready  = ce && !state.w_full;
    assign s_axi_arready = ce && !state.rvalid;
    assign s_axi_bvalid  = state.bvalid;
    assign s_axi_bresp   = state.bresp;
    assign s_axi_rvalid  = state.rvalid;
    assign s_axi_rresp   = state.rresp;
    assign s_axi_rdata   = state.rdata;

    always_comb begin
        next_state = state;
        if (s_axi_awvalid && s_axi_awready) begin
            next_state.aw_full = 1'b1;
            next_state.aw_addr = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_state.w_full = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            next_state.aw_full = 1'b0;
            next_state.w_full  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = wr_known ? pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR;
        end else if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_state.rvalid = 1'b1;
            next_state.rdata  = {24'h000000, rd_value};
            next_state.rresp  = rd_known ? pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR;
        end else if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else if (ce) begin
            state <= next_state;
        end
    end

    pcm_regs u_regs (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .wr_en     (wr_fire && wr_known),
        .wr_addr   (state.aw_addr),
        .wr_data   (wr_byte),
        .latch     (latch),
        .dir       (dir),
        .analog_select_low_lo  (analog_select_low_lo),
        .analog_select_low_hi  (analog_select_low_hi),
        .edge_rate (edge_rate),
        .func_ctrl (func_ctrl)
    );
endmodule : pcm_top

// File: testbench/pcm_props.sv
// Checker of the pin mux outputs and the register bus handshakes.
`timescale 1ns/100ps
module pcm_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [2:0]  pin_in,
    input wire logic [2:0]  pin_oe_n,
    input wire logic        capture_in,
    input wire logic        timer8_count_input,
    input wire logic        timer16_count_input,
    input wire logic        lowpower_osc_in,
    input wire logic        lowpower_osc_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_b_stall; s_axi_bvalid && !s_axi_bready; endsequence
    property p_osc_float; lowpower_osc_in |-> pin_oe_n[2:1] == 2'b11; endproperty
    a_osc_float: assert property (p_osc_float) else $error("oscillator pin driven");
    property p_osc_pair; lowpower_osc_out == lowpower_osc_in; endproperty
    a_osc_pair: assert property (p_osc_pair) else $error("oscillator pins disagree");
    property p_cap_tmr; timer8_count_input == capture_in; endproperty
    a_cap_tmr: assert property (p_cap_tmr) else $error("pin 5 inputs disagree");
    property p_cap_pin; capture_in |-> pin_in[0]; endproperty
    a_cap_pin: assert property (p_cap_pin) else $error("capture input not pin 5");
    property p_t16_pin; timer16_count_input |-> pin_in[1] && !lowpower_osc_in; endproperty
    a_t16_pin: assert property (p_t16_pin) else $error("timer input not pin 6");
    property p_wr; s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
    a_wr: assert property (p_wr) else $error("write response late");
    property p_b_hold; s_b_stall |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read data late");
endmodule : pcm_props

// File: testbench/pcm_board.sv
// Board model that resolves the three pin levels.
`timescale 1ns/100ps
module pcm_board (
    input  wire logic       aclk,     // Core clock
    input  wire logic [2:0] pin_out,  // Mux driven values
    input  wire logic [2:0] pin_oe_n, // Low while the mux drives
    input  wire logic [2:0] ext_en,   // External driver active
    input  wire logic [2:0] ext_val,  // External driver level
    output      logic [2:0] pin_in    // Resolved pin levels
);
    logic [2:0] float_q = 3'h0;
    // An undriven pin has no pull, so it toggles instead of holding a stale level.
    always_ff @(posedge aclk) float_q <= ~float_q;
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : float_q[i]);
        end
    end
endmodule : pcm_board

// File: testbench/pcm_top_tb.sv
// Self-checking bench of the port pin mux against a behavioural model.
`timescale 1ns/100ps
module pcm_top_tb;
    logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, ccp_out_en, ccp_out, pwm_a_en, pwm_a, pwm_shutdown, pwm_sd_hiz;
    logic        serial_active, serial_data_out, osc_enable, capture_in, timer8_count_input;
    logic        timer16_count_input, slave_select_n, analog_channel_eight;
    logic        analog_channel_nine, lowpower_osc_in, lowpower_osc_out, osc, pwm, ccp, ser;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, r, seed;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [4:0]  low_pins_in;
    logic [2:0]  s_axi_awprot, s_axi_arprot, pin_in, pin_out, pin_oe_n, edge_rate_slow;
    logic [2:0]  ext_en, ext_val, e_oe, e_out, e_lvl, e_dig;
    logic [10:0] e_per;
    logic [7:0]  mr [0:6];
    int          error_cnt = 0;
    int          checks_done = 0;
    localparam logic [7:0] MSK [0:6] = '{8'hFF, 8'hFF, 8'hFF, 8'hF8, 8'h0F, 8'h07, 8'h0F};

    pcm_top u_pcm_top (.*);
    pcm_board u_pcm_board (.aclk, .pin_out, .pin_oe_n, .ext_en, .ext_val, .pin_in);

    always_comb begin
        osc = mr[6][3] & osc_enable;
        pwm = mr[6][1] & pwm_a_en;
        ccp = mr[6][0] & ccp_out_en & !mr[2][5];
        ser = mr[6][2] & serial_active & !mr[2][7];
        e_oe[0] = (pwm & pwm_shutdown & pwm_sd_hiz) | (!pwm & mr[2][5]);
        e_oe[2:1] = osc ? 2'h3 : mr[2][7:6];
        e_out = {ser ? serial_data_out : mr[1][7], mr[1][6],
                 pwm ? pwm_a : (ccp ? ccp_out : mr[1][5])};
        e_lvl = (~e_oe & e_out) | (e_oe & ext_val);
        e_dig = e_lvl & {~(osc | mr[4][1]), ~(osc | mr[4][0]), 1'b1};
        e_per = {{2{mr[2][5] & e_dig[0]}}, mr[2][6] & e_dig[1],
                 (mr[2][6] & !osc) ? e_dig[1] : 1'b1, {mr[2][6], mr[2][7]} & {2{!osc}},
                 {2{osc}}, mr[5][2:0]};
    end

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    task static wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic pa, pw, pb, ha, hw, hb;
        logic [1:0] rs;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        {pa, pw, pb} = 3'h7;
        while (pb) begin
            @(negedge aclk);
            {ha, hw, hb, rs} = {pa & s_axi_awready, pw & s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge aclk);
            if (ha) {s_axi_awvalid, pa} <= 2'h0;
            if (hw) {s_axi_wvalid, pw} <= 2'h0;
            if (hb) {s_axi_bready, pb} <= 2'h0;
        end
        chk("bresp", 32'(rs), 32'(a[4:2] < 7 ? pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR));
        if (a[4:2] < 7 && s[0]) mr[a[4:2] == 0 ? 1 : a[4:2]] = d[7:0] & MSK[a[4:2]];
    endtask : wr

    task static rd(input logic [2:0] ix);
        logic pr, hr, ha;
        logic [33:0] got;
        @(posedge aclk);
        s_axi_araddr <= {3'h0, ix, 2'h0};
        {s_axi_arvalid, s_axi_rready, pr} <= 3'h7;
        pr = 1'b1;
        while (pr) begin
            @(negedge aclk);
            {ha, hr, got} = {s_axi_arready, s_axi_rvalid, s_axi_rresp, s_axi_rdata};
            @(posedge aclk);
            if (ha) s_axi_arvalid <= 1'b0;
            if (hr) {s_axi_rready, pr} <= 2'h0;
        end
        chk("rresp", 32'(got[33:32]), 32'(ix < 7 ? pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR));
        chk("rdata", got[31:0] & (ix == 0 ? 32'hFFFFFFE0 : 32'hFFFFFFFF),
            ix == 0 ? {24'h0, e_dig, 5'h0} : (ix < 7 ? {24'h0, mr[ix]} : 32'h0));
    endtask : rd

    initial begin
        {aresetn, s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot, s_axi_arvalid} = '0;
        {s_axi_rready, low_pins_in, ccp_out_en, ccp_out, pwm_a_en, pwm_a, pwm_shutdown} = '0;
        {pwm_sd_hiz, serial_active, serial_data_out, osc_enable, ext_val} = '0;
        {ce, ext_en, seed} = {1'b1, 3'h7, 32'h0000002F};
        mr = '{8'h00, 8'h00, 8'hFF, 8'hF8, 8'h0F, 8'h07, 8'h00};
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 8; i++) rd(3'(i));
        for (int n = 0; n < 300; n++) begin
            r = xs();
            @(posedge aclk);
            {ccp_out, pwm_a, pwm_shutdown, pwm_sd_hiz, serial_active, serial_data_out} <= r[5:0];
            {osc_enable, ext_val, low_pins_in, s_axi_awprot, s_axi_arprot} <= r[20:6];
            {pwm_a_en, ccp_out_en} <= {r[21], r[22] & !r[21]};
            ext_en <= (n % 8 == 7) ? 3'h0 : 3'h7;
            r = xs();
            wr({3'h0, r[2:0], r[4:3]}, xs(), r[8:5] | {3'h0, r[9] | r[10]});
            @(negedge aclk);
            chk("oe", 32'(pin_oe_n), 32'(e_oe));
            chk("out", 32'(pin_out & ~e_oe), 32'(e_out & ~e_oe));
            if (ext_en == 3'h7) begin
                chk("periph", 32'({capture_in, timer8_count_input, timer16_count_input,
                    slave_select_n, analog_channel_eight, analog_channel_nine,
                    lowpower_osc_in, lowpower_osc_out, edge_rate_slow}), 32'(e_per));
                rd(r[13:11]);
            end
        end
        print_verdict();
    end

    initial begin
        repeat (30000) @(posedge aclk);
        error_cnt++;
        print_verdict();
    end
endmodule : pcm_top_tb

bind pcm_top pcm_props u_pcm_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .pin_in, .pin_oe_n, .capture_in, .timer8_count_input,
    .timer16_count_input, .lowpower_osc_in, .lowpower_osc_out);
